// ===== logic/dual_comparator_control.sv
// Control, status and change detection around two analog comparators
//
// Our own choice: register access over AXI4-Lite.
`timescale 1ns/10ps
module dual_comparator_control
  import cmp_ctrl_pkg::*;
(
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic RST_N,
  // AXI4-Lite write address and data
  input wire logic [11:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  // AXI4-Lite write response
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  // AXI4-Lite read
  input wire logic [11:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY,
  // Analog front end: raw comparator results and routing controls
  input wire logic CMP1_RAW,
  input wire logic CMP2_RAW,
  output logic [2:0] CMP1_MINUS_SEL,
  output logic [2:0] CMP1_PLUS_SEL,
  output logic [2:0] CMP2_MINUS_SEL,
  output logic [2:0] CMP2_PLUS_SEL,
  output logic CMP1_POWER,
  output logic CMP2_POWER,
  // Port A pins 0..4
  input wire logic [4:0] PORT_A_PIN_IN,
  input wire logic [4:0] PORT_A_DIRECTION,
  input wire logic [4:0] PORT_A_LATCH,
  output logic [4:0] PORT_A_PIN_OUT,
  output logic [4:0] PORT_A_PIN_OE_N,
  output logic [4:0] PORT_A_ANALOG,
  // Interrupt and wake
  output logic COMPARE_IRQ,
  output logic WAKE_REQ
);

  // Register state; result bits are live views, so only bits 5..0 are stored
  logic [5:0] comparator_control_reg;
  logic compare_change_flag;
  logic compare_change_enable;
  logic peripheral_irq_enable;
  logic global_irq_enable;
  logic [1:0] sync1;
  logic [1:0] sync2;
  logic [1:0] seen;
  logic [1:0] result;
  logic [1:0] raw_result;
  logic [1:0] route_out;
  logic [4:0] analog_pins;
  logic [4:0] pin_sync1;
  logic [4:0] pin_sync2;
  logic [2:0] mode;
  logic input_switch_select;
  logic first_polarity_invert;
  logic second_polarity_invert;
  logic aw_held;
  logic w_held;
  logic [11:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;
  logic do_read;
  logic ctrl_access;
  logic mismatch;
  logic [7:0] ctrl_view;

  // Field views of the control register
  assign mode = comparator_control_reg[2:0];
  assign input_switch_select = comparator_control_reg[SWITCH_BIT];
  assign first_polarity_invert = comparator_control_reg[INV1_BIT];
  assign second_polarity_invert = comparator_control_reg[INV2_BIT];

  // Raw results with polarity applied; these feed pins unsynchronised
  assign raw_result[0] = CMP1_RAW ^ first_polarity_invert;
  assign raw_result[1] = CMP2_RAW ^ second_polarity_invert;

  // Synchronise comparator results and port pins before the core reads them
  always_ff @(posedge CORE_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      sync1 <= 2'h0;
      sync2 <= 2'h0;
      pin_sync1 <= 5'h00;
      pin_sync2 <= 5'h00;
    end
    else
    begin
      sync1 <= raw_result;
      sync2 <= sync1;
      pin_sync1 <= PORT_A_PIN_IN;
      pin_sync2 <= pin_sync1;
    end
  end

  // Result bits forced low while the comparators are off
  // A mode change therefore looks like an output change and may set the flag
  assign result = (mode == MODE_OFF) ? 2'h0 : sync2;

  // Per-mode routing table for inputs, outputs and analog pin use
  always_comb
  begin
    CMP1_MINUS_SEL = SRC_GND;
    CMP1_PLUS_SEL = SRC_GND;
    CMP2_MINUS_SEL = SRC_GND;
    CMP2_PLUS_SEL = SRC_GND;
    CMP1_POWER = 1'b1;
    CMP2_POWER = 1'b1;
    route_out = 2'h0;
    analog_pins = 5'h00;
    case (mode)
      MODE_RESET_ANALOG:
      begin
        analog_pins = 5'h0F;
        CMP1_MINUS_SEL = SRC_PIN0;
        CMP1_PLUS_SEL = SRC_PIN3;
        CMP2_MINUS_SEL = SRC_PIN1;
        CMP2_PLUS_SEL = SRC_PIN2;
      end
      MODE_ONE_MUX:
      begin
        analog_pins = 5'h0F;
        CMP1_MINUS_SEL = input_switch_select ? SRC_PIN3 : SRC_PIN0;
        CMP1_PLUS_SEL = SRC_PIN2;
        CMP2_MINUS_SEL = SRC_PIN1;
        CMP2_PLUS_SEL = SRC_PIN2;
      end
      MODE_FOUR_REF:
      begin
        analog_pins = 5'h0F;
        CMP1_MINUS_SEL = input_switch_select ? SRC_PIN3 : SRC_PIN0;
        CMP2_MINUS_SEL = input_switch_select ? SRC_PIN2 : SRC_PIN1;
        CMP1_PLUS_SEL = SRC_VREF;
        CMP2_PLUS_SEL = SRC_VREF;
      end
      MODE_THREE_SHARED:
      begin
        analog_pins = 5'h07;
        CMP1_MINUS_SEL = SRC_PIN0;
        CMP1_PLUS_SEL = SRC_PIN2;
        CMP2_MINUS_SEL = SRC_PIN1;
        CMP2_PLUS_SEL = SRC_PIN2;
      end
      MODE_TWO_INDEP:
      begin
        analog_pins = 5'h0F;
        CMP1_MINUS_SEL = SRC_PIN0;
        CMP1_PLUS_SEL = SRC_PIN3;
        CMP2_MINUS_SEL = SRC_PIN1;
        CMP2_PLUS_SEL = SRC_PIN2;
      end
      MODE_TWO_SHARED_OUT:
      begin
        analog_pins = 5'h07;
        CMP1_MINUS_SEL = SRC_PIN0;
        CMP1_PLUS_SEL = SRC_PIN2;
        CMP2_MINUS_SEL = SRC_PIN1;
        CMP2_PLUS_SEL = SRC_PIN2;
        route_out = 2'h3;
      end
      MODE_ONE_INDEP:
      begin
        analog_pins = 5'h06;
        CMP1_POWER = 1'b0;
        CMP2_MINUS_SEL = SRC_PIN1;
        CMP2_PLUS_SEL = SRC_PIN2;
      end
      default:
      begin
        CMP1_POWER = 1'b0;
        CMP2_POWER = 1'b0;
      end
    endcase
  end

  // Pin drivers; routed outputs bypass all flops so they follow the analog edge
  always_comb
  begin
    PORT_A_PIN_OUT = PORT_A_LATCH;
    PORT_A_PIN_OUT[3] = route_out[0] ? raw_result[0] : PORT_A_LATCH[3];
    PORT_A_PIN_OUT[4] = route_out[1] ? raw_result[1] : PORT_A_LATCH[4];
    PORT_A_PIN_OE_N = PORT_A_DIRECTION | analog_pins;
    PORT_A_ANALOG = analog_pins;
  end

  // AXI write channel capture; address and data taken in either order
  assign AWREADY = !aw_held && !BVALID;
  assign WREADY = !w_held && !BVALID;
  assign ARREADY = !RVALID;
  assign do_write = aw_held && w_held && !BVALID;
  assign do_read = ARVALID && ARREADY;
  assign ctrl_access = (do_write && aw_addr == CTRL_ADDR) || (do_read && ARADDR == CTRL_ADDR);

  always_ff @(posedge CORE_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 12'h000;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      BVALID <= 1'b0;
      BRESP <= RESP_OKAY;
    end
    else
    begin
      if (AWVALID && AWREADY)
      begin
        aw_held <= 1'b1;
        aw_addr <= AWADDR;
      end
      if (WVALID && WREADY)
      begin
        w_held <= 1'b1;
        w_data <= WDATA;
        w_strb <= WSTRB;
      end
      if (do_write)
      begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        BVALID <= 1'b1;
        BRESP <= (aw_addr == CTRL_ADDR || aw_addr == IRQ_ADDR) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (BVALID && BREADY)
      begin
        BVALID <= 1'b0;
      end
    end
  end

  // Control register; result bits have no storage so writes cannot reach them
  always_ff @(posedge CORE_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      comparator_control_reg <= CTRL_RESET[5:0];
    end
    else if (do_write && aw_addr == CTRL_ADDR && w_strb[0])
    begin
      comparator_control_reg <= w_data[5:0];
    end
  end

  // Mismatch latch: outputs captured on every control register access
  always_ff @(posedge CORE_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      seen <= 2'h0;
    end
    else if (ctrl_access)
    begin
      seen <= result;
    end
  end

  // A change landing on the access cycle is absorbed into the latch, as noted
  assign mismatch = (result != seen) && !ctrl_access;

  // Interrupt flag and enables; hardware set wins over a software clear
  always_ff @(posedge CORE_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      compare_change_flag <= 1'b0;
      compare_change_enable <= 1'b0;
      peripheral_irq_enable <= 1'b0;
      global_irq_enable <= 1'b0;
    end
    else
    begin
      if (do_write && aw_addr == IRQ_ADDR && w_strb[0])
      begin
        compare_change_flag <= w_data[FLAG_BIT] | mismatch;
        compare_change_enable <= w_data[CHG_EN_BIT];
        peripheral_irq_enable <= w_data[PERI_EN_BIT];
        global_irq_enable <= w_data[GLOB_EN_BIT];
      end
      else if (mismatch)
      begin
        compare_change_flag <= 1'b1;
      end
    end
  end

  // Request gated by all three enables; wake needs only the local enables
  assign COMPARE_IRQ = compare_change_flag && compare_change_enable
    && peripheral_irq_enable && global_irq_enable;
  assign WAKE_REQ = compare_change_flag && compare_change_enable
    && peripheral_irq_enable;

  assign ctrl_view = {result[1], result[0], comparator_control_reg[5:0]};

  // Read channel; port reads return 0 on analog pins
  always_ff @(posedge CORE_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      RVALID <= 1'b0;
      RDATA <= 32'h00000000;
      RRESP <= RESP_OKAY;
    end
    else if (do_read)
    begin
      RVALID <= 1'b1;
      RRESP <= RESP_OKAY;
      case (ARADDR)
        CTRL_ADDR: RDATA <= {24'h000000, ctrl_view};
        IRQ_ADDR: RDATA <= {28'h0000000, global_irq_enable, peripheral_irq_enable,
          compare_change_enable, compare_change_flag};
        PORT_ADDR: RDATA <= {27'h0000000, pin_sync2 & ~analog_pins};
        default:
        begin
          RDATA <= 32'h00000000;
          RRESP <= RESP_SLVERR;
        end
      endcase
    end
    else if (RVALID && RREADY)
    begin
      RVALID <= 1'b0;
    end
  end

endmodule : dual_comparator_control

// ===== logic/cmp_ctrl_pkg.sv
// Constants, field positions and mode encodings for the dual comparator control block
package cmp_ctrl_pkg;
  // Register byte addresses
  localparam logic [11:0] CTRL_ADDR = 12'h09C;
  localparam logic [11:0] IRQ_ADDR = 12'h0A0;
  localparam logic [11:0] PORT_ADDR = 12'h0A4;
  // Control register fields
  localparam int RES2_BIT = 7;
  localparam int RES1_BIT = 6;
  localparam int INV2_BIT = 5;
  localparam int INV1_BIT = 4;
  localparam int SWITCH_BIT = 3;
  localparam logic [7:0] CTRL_RESET = 8'h07;
  // Interrupt register fields
  localparam int FLAG_BIT = 0;
  localparam int CHG_EN_BIT = 1;
  localparam int PERI_EN_BIT = 2;
  localparam int GLOB_EN_BIT = 3;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Comparator modes
  typedef enum logic [2:0] {
    MODE_RESET_ANALOG = 3'h0,
    MODE_ONE_MUX = 3'h1,
    MODE_FOUR_REF = 3'h2,
    MODE_THREE_SHARED = 3'h3,
    MODE_TWO_INDEP = 3'h4,
    MODE_TWO_SHARED_OUT = 3'h5,
    MODE_ONE_INDEP = 3'h6,
    MODE_OFF = 3'h7
  } mode_t;
  // Input source selectors: pins 0..3, internal reference, ground
  typedef enum logic [2:0] {
    SRC_PIN0 = 3'h0,
    SRC_PIN1 = 3'h1,
    SRC_PIN2 = 3'h2,
    SRC_PIN3 = 3'h3,
    SRC_VREF = 3'h4,
    SRC_GND = 3'h5
  } src_t;
endpackage : cmp_ctrl_pkg

// ===== bench/cmp_ctrl_asserts.sv
// Port-level checker for the dual comparator control block
`timescale 1ns/10ps
module cmp_ctrl_asserts
  import cmp_ctrl_pkg::*;
(
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic RST_N,
  // Bus handshakes
  input wire logic AWVALID,
  input wire logic AWREADY,
  input wire logic WVALID,
  input wire logic WREADY,
  input wire logic [1:0] BRESP,
  input wire logic BVALID,
  input wire logic BREADY,
  input wire logic ARVALID,
  input wire logic ARREADY,
  input wire logic [31:0] RDATA,
  input wire logic RVALID,
  input wire logic RREADY,
  // Interrupt and port
  input wire logic COMPARE_IRQ,
  input wire logic WAKE_REQ,
  input wire logic [4:0] PORT_A_DIRECTION,
  input wire logic [4:0] PORT_A_PIN_OE_N
);
  // One domain, so clock and reset are given once
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!RST_N);
  wr_refused_a: assert property (BVALID |-> !AWREADY && !WREADY)
    else $error("write taken while response pending");
  rd_refused_a: assert property (RVALID |-> !ARREADY)
    else $error("read taken while data pending");
  bresp_holds_a: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
    else $error("write response dropped early");
  rdata_holds_a: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
    else $error("read data dropped early");
  rd_answer_a: assert property (ARVALID && ARREADY |-> ##[1:2] RVALID)
    else $error("read not answered");
  wr_answer_a: assert property (AWVALID && AWREADY && WVALID && WREADY |-> ##[1:3] BVALID)
    else $error("write not answered");
  irq_gated_a: assert property (COMPARE_IRQ |-> WAKE_REQ)
    else $error("request without its enables");
  dir_enable_a: assert property ((PORT_A_DIRECTION[4:3] & ~PORT_A_PIN_OE_N[4:3]) == 2'h0)
    else $error("input pin driven");
endmodule : cmp_ctrl_asserts

bind dual_comparator_control cmp_ctrl_asserts u_chk (.*);

// ===== bench/analog_front.sv
// Behavioural model of the two comparators and their input voltages
`timescale 1ns/10ps
module analog_front
  import cmp_ctrl_pkg::*;
(
  // Selections and power from the block
  input wire logic [2:0] plus1,
  input wire logic [2:0] minus1,
  input wire logic [2:0] plus2,
  input wire logic [2:0] minus2,
  input wire logic pwr1,
  input wire logic pwr2,
  // Pins 0..3, reference, ground
  input wire logic [7:0] volt [6],
  // Raw results
  output logic raw1,
  output logic raw2
);
  // Strict compare; an unpowered comparator rests low
  function automatic logic cmp(input logic [2:0] p, input logic [2:0] m);
    return p < 6 && m < 6 && volt[p] > volt[m];
  endfunction : cmp
  assign raw1 = pwr1 && cmp(plus1, minus1);
  assign raw2 = pwr2 && cmp(plus2, minus2);
endmodule : analog_front

// ===== bench/testbench.sv
// Self-checking bench for the dual comparator control block
`timescale 1ns/10ps
module testbench
  import cmp_ctrl_pkg::*;
;
  logic CORE_CLK = 0, RST_N = 0;
  logic [11:0] AWADDR = 0, ARADDR = 0;
  logic [31:0] WDATA = 0, RDATA, rdv;
  logic [3:0] WSTRB = 4'hF;
  logic AWVALID = 0, WVALID = 0, BREADY = 0, ARVALID = 0, RREADY = 0;
  logic AWREADY, WREADY, BVALID, ARREADY, RVALID, COMPARE_IRQ, WAKE_REQ;
  logic [1:0] BRESP, RRESP, rs, inv;
  logic CMP1_RAW, CMP2_RAW, CMP1_POWER, CMP2_POWER, sw;
  logic [2:0] CMP1_MINUS_SEL, CMP1_PLUS_SEL, CMP2_MINUS_SEL, CMP2_PLUS_SEL;
  logic [4:0] PORT_A_PIN_IN = 0, PORT_A_DIRECTION = 5'h1F, PORT_A_LATCH = 0;
  logic [4:0] PORT_A_PIN_OUT, PORT_A_PIN_OE_N, PORT_A_ANALOG;
  logic [7:0] volt [6] = '{default: 8'h00};
  int mismatches = 0, checks_done = 0, seed = 28939;
  dual_comparator_control DUT (.*);
  analog_front u_front (.plus1(CMP1_PLUS_SEL), .minus1(CMP1_MINUS_SEL),
    .plus2(CMP2_PLUS_SEL), .minus2(CMP2_MINUS_SEL), .pwr1(CMP1_POWER),
    .pwr2(CMP2_POWER), .volt(volt), .raw1(CMP1_RAW), .raw2(CMP2_RAW));
  // Free-running core clock
  initial forever #10 CORE_CLK = ~CORE_CLK;
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // Ready is sampled at the falling edge, where it equals its rising-edge value
  // Response ready is held back a random few cycles so the hold checks are reached
  task automatic bus_wr(input logic [11:0] a, input logic [31:0] d);
    logic aw, w, b;
    int k;
    b = 0;
    k = $random(seed) & 3;
    @(posedge CORE_CLK);
    AWADDR <= a;
    WDATA <= d;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= (k == 0);
    while (!b)
    begin
      @(negedge CORE_CLK);
      aw = AWREADY;
      w = WREADY;
      b = BVALID && BREADY;
      rs = BRESP;
      @(posedge CORE_CLK);
      if (aw) AWVALID <= 1'b0;
      if (w) WVALID <= 1'b0;
      k--;
      if (!b && k <= 0) BREADY <= 1'b1;
    end
    BREADY <= 1'b0;
  endtask : bus_wr
  task automatic bus_rd(input logic [11:0] a);
    logic ar, r;
    int k;
    r = 0;
    k = $random(seed) & 3;
    @(posedge CORE_CLK);
    ARADDR <= a;
    ARVALID <= 1'b1;
    RREADY <= (k == 0);
    while (!r)
    begin
      @(negedge CORE_CLK);
      ar = ARREADY;
      r = RVALID && RREADY;
      rdv = RDATA;
      rs = RRESP;
      @(posedge CORE_CLK);
      if (ar) ARVALID <= 1'b0;
      k--;
      if (!r && k <= 0) RREADY <= 1'b1;
    end
    RREADY <= 1'b0;
  endtask : bus_rd
  task automatic flag_is(input logic f);
    bus_rd(IRQ_ADDR);
    chk("flag", 32'(rdv[FLAG_BIT]), 32'(f));
  endtask : flag_is
  // Expected results in the reference mode
  function automatic logic [1:0] res(input logic [1:0] iv, input logic s);
    return {(volt[4] > volt[s ? 2 : 1]) ^ iv[1], (volt[4] > volt[s ? 3 : 0]) ^ iv[0]};
  endfunction : res
  task automatic settle(input int n);
    repeat (n) @(posedge CORE_CLK);
  endtask : settle
  task automatic final_report;
    if (mismatches == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : final_report
  // Main sequence
  initial
  begin
    settle(10);
    RST_N <= 1'b1;
    bus_rd(CTRL_ADDR);
    chk("ctrl reset", rdv, 32'h07);
    flag_is(0);
    bus_wr(12'h100, 0);
    chk("bad write", 32'(rs), 32'(RESP_SLVERR));
    bus_rd(12'h100);
    chk("bad read", 32'(rs), 32'(RESP_SLVERR));
    // Every mode; result bits stay low though written high
    for (int m = 0; m < 8; m++)
    begin
      sw = 1'($random(seed));
      bus_wr(CTRL_ADDR, {24'h0, 4'hC, sw, 3'(m)});
      bus_rd(CTRL_ADDR);
      chk("mode", rdv, {27'h0, sw, 3'(m)});
      if (m == 1) chk("c1 minus", 32'(CMP1_MINUS_SEL), sw ? 32'h3 : 32'h0);
      chk("power", 32'({CMP1_POWER, CMP2_POWER}), (m == 7) ? 32'h0 : (m == 6) ? 32'h1 : 32'h3);
    end
    // Reference mode with random levels and polarity
    repeat (12)
    begin
      inv = 2'($random(seed));
      sw = 1'($random(seed));
      @(posedge CORE_CLK);
      for (int i = 0; i < 5; i++) volt[i] <= 8'($random(seed));
      bus_wr(CTRL_ADDR, {24'h0, 2'b11, inv, sw, 3'h2});
      settle(5);
      bus_rd(CTRL_ADDR);
      chk("plus", 32'({CMP1_PLUS_SEL, CMP2_PLUS_SEL}), 32'({SRC_VREF, SRC_VREF}));
      chk("minus", 32'({CMP1_MINUS_SEL, CMP2_MINUS_SEL}), sw ? 32'h1A : 32'h01);
      chk("results", 32'(rdv[7:6]), 32'(res(inv, sw)));
    end
    // Mismatch keeps the flag until the control register is touched
    @(posedge CORE_CLK);
    for (int i = 0; i < 4; i++) volt[i] <= 8'h80;
    volt[4] <= 8'h10;
    settle(5);
    bus_rd(CTRL_ADDR);
    bus_wr(IRQ_ADDR, 0);
    flag_is(0);
    @(posedge CORE_CLK);
    volt[4] <= 8'hF0;
    settle(5);
    flag_is(1);
    bus_wr(IRQ_ADDR, 0);
    flag_is(1);
    bus_rd(CTRL_ADDR);
    bus_wr(IRQ_ADDR, 0);
    flag_is(0);
    // Software set and every enable combination
    for (int e = 0; e < 8; e++)
    begin
      bus_wr(IRQ_ADDR, {28'h0, 3'(e), 1'b1});
      @(negedge CORE_CLK);
      chk("irq", 32'(COMPARE_IRQ), 32'(e == 7));
      chk("wake", 32'(WAKE_REQ), 32'((e & 3) == 3));
      bus_rd(IRQ_ADDR);
      chk("irq reg", rdv, {28'h0, 3'(e), 1'b1});
    end
    bus_wr(IRQ_ADDR, 0);
    // Routed outputs follow the raw results at once
    repeat (6)
    begin
      inv = 2'($random(seed));
      @(posedge CORE_CLK);
      PORT_A_LATCH <= 5'($random(seed));
      PORT_A_DIRECTION <= 5'($random(seed));
      for (int i = 0; i < 5; i++) volt[i] <= 8'($random(seed));
      bus_wr(CTRL_ADDR, {24'h0, 2'b00, inv, 1'b0, 3'h5});
      @(negedge CORE_CLK);
      chk("pins", 32'(PORT_A_PIN_OUT),
        32'({CMP2_RAW ^ inv[1], CMP1_RAW ^ inv[0], PORT_A_LATCH[2:0]}));
      chk("oe", 32'(PORT_A_PIN_OE_N), 32'({PORT_A_DIRECTION[4:3], 3'h7}));
      chk("analog", 32'(PORT_A_ANALOG), 32'h07);
    end
    // Port read with no analog pins
    bus_wr(CTRL_ADDR, 32'h07);
    @(posedge CORE_CLK);
    PORT_A_PIN_IN <= 5'($random(seed));
    settle(4);
    bus_rd(PORT_ADDR);
    chk("port", rdv, 32'(PORT_A_PIN_IN));
    // Reset analog mode puts pins 0..3 in analog use, so they read 0
    bus_wr(CTRL_ADDR, 32'h00);
    bus_rd(PORT_ADDR);
    chk("port analog", rdv, 32'({PORT_A_PIN_IN[4], 4'h0}));
    final_report;
  end
  // Watchdog well beyond the expected run
  initial
  begin
    settle(20000);
    mismatches++;
    final_report;
  end
endmodule : testbench
